// ===== design/xdata_ram_map.vh
// address map, field layout and reset values of the on-chip data ram decoder
`ifndef XDATA_RAM_MAP_VH
`define XDATA_RAM_MAP_VH

// ----------------------------------------------------------------
// ram window
// ----------------------------------------------------------------
`define XR_WIN_BASE   16'hF800
`define XR_ADDR_W     11
`define XR_DEPTH      2048

// ----------------------------------------------------------------
// register indices as printed and byte addresses on the bus
// ----------------------------------------------------------------
`define PAGE_IDX      12'h091
`define PAGE_ADDR     12'h244
`define SYSC_IDX      12'h0B1
`define SYSC_ADDR     12'h2C4
`define STAT_ADDR     12'h300

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PAGE_RST      8'h00
`define SYSC_DIS_BIT  0
`define SYSC_VIS_BIT  1
`define SYSC_RST      2'h1
`define SYSC_DIS_RST  1'b1
`define SYSC_VIS_RST  1'b0
`define PORT2_RST     8'hFF
`define STAT_BUSY_BIT 0
`define STAT_INT_BIT  1
`define STAT_EN_BIT   2

`endif

// ===== design/onchip_xdata_ram.v
// 2K x 8 on-chip data ram, registered read, no reset on the array
`timescale 1ns/100ps
`include "xdata_ram_map.vh"

module onchip_xdata_ram (
   input  wire                      clk,
   input  wire                      ce,
   input  wire                      we,
   input  wire [`XR_ADDR_W-1:0]     addr,
   input  wire [7:0]                wdata,
   output reg  [7:0]                rdata
);

   // array deliberately not reset so contents survive a system reset
   reg [7:0] mem [0:`XR_DEPTH-1];

   // ----------------------------------------------------------------
   // write and registered read
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end

endmodule

// ===== design/pin_sync8.v
// two flip-flop synchroniser for an 8-bit pin input group
`timescale 1ns/100ps

module pin_sync8 (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire [7:0]  d,
   output wire [7:0]  q
);

   reg [7:0] meta_reg;
   reg [7:0] sync_reg;

   // ----------------------------------------------------------------
   // per-bit double flop, first stage read only by the second
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
            end else if (ce) begin
               meta_reg[i] <= d[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign q = sync_reg;

endmodule

// ===== design/xdata_ram_decode.v
// decode and access control for the on-chip data ram behind external moves
`timescale 1ns/100ps
`include "xdata_ram_map.vh"

module xdata_ram_decode (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   // apb register port
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // move requests from the cpu core
   input  wire        mv_req,
   input  wire        mv_write,
   input  wire        mv_use_data_pointer,
   input  wire [15:0] data_pointer,
   input  wire [7:0]  index_register_low,
   input  wire [7:0]  mv_wdata,
   output reg  [7:0]  mv_rdata,
   output reg         mv_done,
   // port two latch writes from the core
   input  wire        port_two_wr,
   input  wire [7:0]  port_two_wdata,
   // external bus pins
   output reg  [15:0] ext_addr,
   output reg         ext_addr_oe,
   output reg  [7:0]  ext_data_out,
   output reg         ext_data_oe,
   input  wire [7:0]  ext_data_in,
   output reg         ext_rd_n,
   output reg         ext_wr_n
);

   // ----------------------------------------------------------------
   // move sequencer states
   // ----------------------------------------------------------------
   // one-hot; busy is any state but idle
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_C1   = 4'h2;
   localparam [3:0] ST_C2   = 4'h4;
   localparam [3:0] ST_C3   = 4'h8;

   // ----------------------------------------------------------------
   // window decode, used for the route and for strobe visibility
   // ----------------------------------------------------------------
   // window sits at the top of the space, so one compare covers it
   function in_window;
      input [15:0] addr;
      begin
         in_window = (addr >= `XR_WIN_BASE);
      end
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg  [7:0]  page_reg;
   reg  [7:0]  page_next;
   reg  [7:0]  port_two_reg;
   reg         ram_dis_reg;
   reg         vis_reg;
   reg  [3:0]  state_reg;
   reg  [15:0] addr_reg;
   reg  [7:0]  wdata_reg;
   reg         wr_reg;
   reg         int_reg;
   reg         show_reg;
   reg         last_int_reg;
   reg  [15:0] eff_addr;
   reg  [15:0] pin_addr;
   reg         route_int;
   reg  [31:0] rd_mux;
   reg         rd_err;
   wire [7:0]  ram_rdata;
   wire [7:0]  ext_sync;
   wire        ram_we;
   wire        apb_acc;
   wire        apb_wr;
   wire        show_now;

   // access phase while no answer is out yet
   assign apb_acc = psel & penable & ~pready;
   // writes take effect on the edge where the master sees pready
   assign apb_wr  = psel & penable & pready & pwrite;

   // ----------------------------------------------------------------
   // effective address and route
   // ----------------------------------------------------------------
   // pointer moves use the full pointer, index moves page:index;
   // an external index move puts the port two latch byte on the pins
   always @* begin
      if (mv_use_data_pointer) begin
         eff_addr = data_pointer;
         pin_addr = data_pointer;
      end else begin
         eff_addr = {page_reg, index_register_low};
         pin_addr = {port_two_reg, index_register_low};
      end
      // disabled ram sends everything out, window gate otherwise
      route_int = ~ram_dis_reg & in_window(eff_addr);
   end

   // pins and strobes follow an external move, an internal one only
   // with visibility; the bit means nothing off-window
   assign show_now = ~route_int | vis_reg;

   // ----------------------------------------------------------------
   // ram and pin synchroniser
   // ----------------------------------------------------------------
   // commit on the edge leaving cycle 1, so a reset inside cycle 1
   // drops the write and a reset in cycle 2 leaves it stored
   assign ram_we = (state_reg == ST_C1) & int_reg & wr_reg;

   onchip_xdata_ram u_ram (
      .clk   (pclk),
      .ce    (ce),
      .we    (ram_we),
      .addr  (addr_reg[`XR_ADDR_W-1:0]),
      .wdata (wdata_reg),
      .rdata (ram_rdata)
   );

   // the pin byte is read only through the two-flop synchroniser
   pin_sync8 u_din_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (ce),
      .d     (ext_data_in),
      .q     (ext_sync)
   );

   // ----------------------------------------------------------------
   // page register next value
   // ----------------------------------------------------------------
   // a port two write wins a same-cycle bus write; the latch byte
   // must land in the page so external pages deselect the ram
   always @* begin
      page_next = page_reg;
      if (apb_wr && paddr == `PAGE_ADDR) begin
         page_next = pwdata[7:0];
      end
      if (port_two_wr) begin
         page_next = port_two_wdata;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // disable bit is clear-only; upper control bits are not stored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_reg     <= `PAGE_RST;
         port_two_reg <= `PORT2_RST;
         ram_dis_reg  <= `SYSC_DIS_RST;
         vis_reg      <= `SYSC_VIS_RST;
      end else if (ce) begin
         page_reg <= page_next;
         if (port_two_wr) begin
            port_two_reg <= port_two_wdata;
         end
         if (apb_wr && paddr == `SYSC_ADDR) begin
            // only a clear gets through; set needs a reset
            if (!pwdata[`SYSC_DIS_BIT]) begin
               ram_dis_reg <= 1'b0;
            end
            vis_reg <= pwdata[`SYSC_VIS_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // apb read mux and decode
   // ----------------------------------------------------------------
   // unmapped offsets answer with an error and read zero
   always @* begin
      rd_mux = 32'h00000000;
      rd_err = 1'b0;
      case (paddr)
         `PAGE_ADDR: begin
            rd_mux[7:0] = page_reg;
         end
         `SYSC_ADDR: begin
            rd_mux[`SYSC_DIS_BIT] = ram_dis_reg;
            rd_mux[`SYSC_VIS_BIT] = vis_reg;
         end
         `STAT_ADDR: begin
            rd_mux[`STAT_BUSY_BIT] = (state_reg != ST_IDLE);
            rd_mux[`STAT_INT_BIT]  = last_int_reg;
            rd_mux[`STAT_EN_BIT]   = ~ram_dis_reg;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // apb answer, one wait state
   // ----------------------------------------------------------------
   // registered answer keeps the read mux off the output path
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         if (apb_acc) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= rd_err;
         end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // move sequencer
   // ----------------------------------------------------------------
   // same length for every route, so an internal read returns with
   // the same timing as an external one; the length is set by the
   // pin byte, which needs two flops after the address goes out
   // before it can be taken, so the byte is taken on the fourth edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= ST_IDLE;
         addr_reg     <= 16'h0000;
         wdata_reg    <= 8'h00;
         wr_reg       <= 1'b0;
         int_reg      <= 1'b0;
         show_reg     <= 1'b0;
         last_int_reg <= 1'b0;
         mv_rdata     <= 8'h00;
         mv_done      <= 1'b0;
         ext_addr     <= 16'h0000;
         ext_addr_oe  <= 1'b0;
         ext_data_out <= 8'h00;
         ext_data_oe  <= 1'b0;
         ext_rd_n     <= 1'b1;
         ext_wr_n     <= 1'b1;
      end else if (ce) begin
         mv_done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // a request while busy is never seen here
               if (mv_req) begin
                  state_reg    <= ST_C1;
                  addr_reg     <= eff_addr;
                  wdata_reg    <= mv_wdata;
                  wr_reg       <= mv_write;
                  int_reg      <= route_int;
                  last_int_reg <= route_int;
                  // route and pin decision frozen for the whole move
                  show_reg     <= show_now;
                  if (show_now) begin
                     ext_addr    <= route_int ? eff_addr : pin_addr;
                     ext_addr_oe <= 1'b1;
                  end
               end
            end
            ST_C1: begin
               // a shown move drops its strobe here
               state_reg <= ST_C2;
               if (show_reg) begin
                  ext_rd_n     <= wr_reg;
                  ext_wr_n     <= ~wr_reg;
                  ext_data_out <= wdata_reg;
                  ext_data_oe  <= wr_reg;
               end
            end
            ST_C2: begin
               // strobe held while the pin byte crosses the synchroniser
               state_reg <= ST_C3;
            end
            ST_C3: begin
               // strobes rise, pins released, byte handed over
               state_reg   <= ST_IDLE;
               mv_done     <= 1'b1;
               ext_rd_n    <= 1'b1;
               ext_wr_n    <= 1'b1;
               ext_addr_oe <= 1'b0;
               ext_data_oe <= 1'b0;
               if (!wr_reg) begin
                  mv_rdata <= int_reg ? ram_rdata : ext_sync;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// ===== tb/xdata_ram_decode_sva.sv
// port-level checks for the move decoder
`timescale 1ns/100ps
`include "xdata_ram_map.vh"
module xdata_ram_decode_sva (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pready,
   input logic        pslverr,
   input logic        mv_req,
   input logic        mv_write,
   input logic        mv_use_data_pointer,
   input logic [15:0] data_pointer,
   input logic [7:0]  mv_wdata,
   input logic [7:0]  mv_rdata,
   input logic        mv_done,
   input logic [15:0] ext_addr,
   input logic        ext_addr_oe,
   input logic [7:0]  ext_data_out,
   input logic        ext_data_oe,
   input logic        ext_rd_n,
   input logic        ext_wr_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a taken move ends exactly four edges later
   sequence s_gap;
      !mv_done [*3];
   endsequence
   sequence s_end;
      s_gap ##1 mv_done;
   endsequence
   // pointer below the window, and any strobe
   wire ptr_low = data_pointer < `XR_WIN_BASE;
   wire strobe  = !ext_rd_n || !ext_wr_n;
   take_done_a: assert property (mv_req |=> s_end)
      else $error("move did not end after four cycles");
   rd_pulse_a: assert property ($fell(ext_rd_n) |-> $past(mv_req, 2) ##2 ext_rd_n)
      else $error("read strobe out of place");
   wr_pulse_a: assert property ($fell(ext_wr_n) |-> $past(mv_write, 2) ##2 ext_wr_n)
      else $error("write strobe out of place");
   strobe_addr_a: assert property (strobe |-> ext_addr_oe)
      else $error("strobe without address on pins");
   wr_drive_a: assert property (!ext_wr_n |-> ext_data_oe)
      else $error("write strobe without data drive");
   low_ext_a: assert property (mv_req && mv_use_data_pointer && ptr_low |-> ##2 strobe)
      else $error("low pointer move not external");
   low_addr_a: assert property (mv_req && mv_use_data_pointer && ptr_low
      |=> ext_addr_oe && ext_addr == $past(data_pointer))
      else $error("external address wrong");
   low_wdata_a: assert property (mv_req && mv_write && mv_use_data_pointer && ptr_low
      |-> ##2 ext_data_out == $past(mv_wdata, 2))
      else $error("external write data wrong");
   rdata_hold_a: assert property (!mv_done |-> $stable(mv_rdata))
      else $error("read byte changed outside done");
   apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("register answer timing wrong");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule
bind xdata_ram_decode xdata_ram_decode_sva u_xdata_ram_decode_sva (.*);

// ===== tb/ext_mem_model.sv
// external data memory on the pins, decoded on the low address byte
`timescale 1ns/100ps
module ext_mem_model (
   input  logic        pclk,
   input  logic [15:0] ext_addr,
   input  logic        ext_addr_oe,
   input  logic [7:0]  ext_data_out,
   input  logic        ext_data_oe,
   input  logic        ext_wr_n,
   output logic [7:0]  ext_data_in
);
   logic [7:0] mem [0:255];
   logic [7:0] last;
   wire        drive = ext_addr_oe && !ext_data_oe;
   // known pattern so external reads differ from the on-chip array
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = i[7:0] ^ 8'h5A;
      end
      last = 8'h00;
   end
   // store while write strobe low, remember last byte driven
   always @(posedge pclk) begin
      if (!ext_wr_n && ext_data_oe) begin
         mem[ext_addr[7:0]] <= ext_data_out;
      end
      if (drive) begin
         last <= mem[ext_addr[7:0]];
      end
   end
   // released bus shows the inverse, never a stale copy
   assign ext_data_in = drive ? mem[ext_addr[7:0]] : ~last;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the move decoder
`timescale 1ns/100ps
`include "xdata_ram_map.vh"
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        mv_req, mv_write, mv_use_data_pointer, mv_done, port_two_wr;
   logic [15:0] data_pointer, ext_addr, cap_a;
   logic [7:0]  index_register_low, mv_wdata, mv_rdata, port_two_wdata, cap_d;
   logic [7:0]  ext_data_out, ext_data_in;
   logic        ext_addr_oe, ext_data_oe, ext_rd_n, ext_wr_n;
   int          failures, n_checks;
   typedef struct packed {logic w; logic dp; logic [15:0] a; logic [7:0] d; logic x;} row_t;
   localparam row_t rows [10] = '{'{1, 1, 16'hF800, 8'h11, 0}, '{1, 1, 16'hFFFF, 8'h22, 0},
      '{1, 1, 16'h07FF, 8'h33, 1}, '{0, 1, 16'hF800, 8'h11, 0}, '{0, 1, 16'hFFFF, 8'h22, 0},
      '{0, 1, 16'hF7FF, 8'h33, 1}, '{1, 0, 16'hF805, 8'h44, 0}, '{0, 0, 16'hF805, 8'h44, 0},
      '{0, 1, 16'hF805, 8'h44, 0}, '{0, 0, 16'hF7FF, 8'h33, 1}};
   xdata_ram_decode u_xdata_ram_decode (.ce(1'b1), .*);
   ext_mem_model u_ext_mem_model (.*);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // strobes seen during a move, with the pins at that time
   always @(posedge pclk) begin
      if (mv_req) begin
         seen <= 1'b0;
      end else if (!ext_rd_n || !ext_wr_n) begin
         seen <= 1'b1;
         cap_a <= ext_addr;
         cap_d <= ext_data_out;
      end
   end
   // ----
   // tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // bounded wait; running out ends the run as a mismatch
   task automatic wait_hi(ref logic sig);
      int i;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (sig !== 1'b1 && i < 20);
      if (sig !== 1'b1) begin
         failures++;
         complete_run();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wait_hi(pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // rst 1 or 2 pulls reset in that cycle of the move
   task automatic mv(input logic w, dp, input logic [15:0] a, input logic [7:0] d, input int rst);
      @(posedge pclk);
      mv_req <= 1'b1;
      mv_write <= w;
      mv_use_data_pointer <= dp;
      data_pointer <= a;
      index_register_low <= a[7:0];
      mv_wdata <= d;
      @(posedge pclk);
      mv_req <= 1'b0;
      if (rst == 1) presetn <= 1'b0;
      @(posedge pclk);
      if (rst == 2) presetn <= 1'b0;
      if (rst != 0) begin
         repeat (2) @(posedge pclk);
         presetn <= 1'b1;
      end else wait_hi(mv_done);
   endtask
   initial begin
      failures = 0;
      n_checks = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata, port_two_wr, port_two_wdata} = '0;
      {mv_req, mv_write, mv_use_data_pointer, data_pointer, index_register_low, mv_wdata} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `PAGE_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `SYSC_ADDR, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 12'h100, 32'h0);
      chk(err, 1'b1);
      mv(1'b1, 1'b1, 16'hFFF0, 8'hAA, 0);
      chk(seen, 1'b1);
      apb(1'b1, `SYSC_ADDR, 32'h0);
      apb(1'b1, `SYSC_ADDR, 32'h1);
      apb(1'b0, `SYSC_ADDR, 32'h0);
      chk(rd, 32'h0);
      // table of moves, page loaded from each address
      foreach (rows[i]) begin
         apb(1'b1, `PAGE_ADDR, {24'h0, rows[i].a[15:8]});
         mv(rows[i].w, rows[i].dp, rows[i].a, rows[i].d, 0);
         chk(seen, rows[i].x);
         if (!rows[i].w) chk(mv_rdata, rows[i].d);
         if (rows[i].x) chk(cap_a, rows[i].dp ? rows[i].a : {8'hFF, rows[i].a[7:0]});
      end
      // port two write also lands in the page register
      @(posedge pclk);
      port_two_wr <= 1'b1;
      port_two_wdata <= 8'hF9;
      @(posedge pclk);
      port_two_wr <= 1'b0;
      apb(1'b0, `PAGE_ADDR, 32'h0);
      chk(rd, 32'hF9);
      apb(1'b1, `SYSC_ADDR, 32'h2);
      mv(1'b1, 1'b1, 16'hF810, 8'h55, 0);
      chk(cap_d, 8'h55);
      mv(1'b0, 1'b1, 16'hF800, 8'h00, 0);
      chk(mv_rdata, 8'h11);
      apb(1'b0, `STAT_ADDR, 32'h0);
      chk(rd, 32'h6);
      // reset in cycle 1 and in cycle 2 of a write
      mv(1'b1, 1'b1, 16'hF820, 8'h77, 0);
      mv(1'b1, 1'b1, 16'hF820, 8'h66, 1);
      apb(1'b1, `SYSC_ADDR, 32'h0);
      mv(1'b0, 1'b1, 16'hF820, 8'h00, 0);
      chk(mv_rdata, 8'h77);
      mv(1'b1, 1'b1, 16'hF820, 8'h88, 2);
      apb(1'b0, `SYSC_ADDR, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, `SYSC_ADDR, 32'h0);
      mv(1'b0, 1'b1, 16'hF820, 8'h00, 0);
      chk(mv_rdata, 8'h88);
      complete_run();
   end
endmodule
